// [hw/axis_request_warning_checker.v]
// Functional notes
// - unit warnings reported as codes from 0xb000, apart from amplifier warnings
// - torque limit request during amplifier parameter/monitor work: skipped, warning 0xb004
// - start on a busy axis is refused with warning 0xb010
// - deceleration, emergency and system stops accepted while operating, no warning
// - positioning request to an absent axis starts nothing, warning 0xb020
// - point speed change and point start together in point mode: warning 0xb030
// - on that collision the point start acts, the speed change is dropped
// - point speed change while accelerating or decelerating: warning 0xb030
// - point speed change with point control inactive: ignored, warning 0xb031
// - point start with point control inactive: ignored, warning 0xb032
// - torque leaving its judgment band raises warning 0xb050
// - torque warning only when judgment bits 0 and 1 are both set
// - actual speed leaving its judgment band raises warning 0xb051
// - speed warning only when judgment bits 2 and 3 are both set
`timescale 1ns/1ps
`include "axis_warn_defs.vh"
module axis_request_warning_checker (
    input  wire                       pclk,
    input  wire                       presetn,
    input  wire                       psel,
    input  wire                       penable,
    input  wire                       pwrite,
    input  wire [11:0]                paddr,
    input  wire [31:0]                pwdata,
    output reg  [31:0]                prdata,
    output reg                        pready,
    output reg                        pslverr,
    input  wire [`AXES-1:0]           start_req,
    input  wire [`AXES-1:0]           decel_stop_req,
    input  wire [`AXES-1:0]           emg_stop_req,
    input  wire                       sys_stop_req,
    input  wire [`AXES-1:0]           torque_limit_req,
    input  wire [`AXES-1:0]           point_start_req,
    input  wire [`AXES-1:0]           point_speed_req,
    input  wire [`AXES-1:0]           axis_busy,
    input  wire [`AXES-1:0]           axis_ramping,
    input  wire [`AXES-1:0]           point_active,
    input  wire                       amp_param_busy,
    input  wire                       amp_mon_busy,
    input  wire [`AXES*`MON_W-1:0]    torque_mon,
    input  wire [`AXES*`MON_W-1:0]    speed_mon,
    output reg  [`AXES-1:0]           start_grant,
    output reg  [`AXES-1:0]           stop_grant,
    output reg  [`AXES-1:0]           torque_limit_apply,
    output reg  [`AXES-1:0]           point_start_grant,
    output reg  [`AXES-1:0]           speed_change_grant,
    output reg                        warn_valid,
    output reg  [15:0]                warn_code,
    output reg  [1:0]                 warn_axis,
    output reg                        irq
);
    localparam NA = `AXES;
    localparam SW = `AXES * `WTYPES;

    // ----------------------------------------
    // host contacts
    // ----------------------------------------
    wire [6*NA:0] pins_raw;
    wire [6*NA:0] pins_lvl;
    reg  [6*NA:0] pins_old_ff;
    wire [6*NA:0] pins_rise;

    assign pins_raw  = {sys_stop_req, point_speed_req, point_start_req, torque_limit_req,
                        emg_stop_req, decel_stop_req, start_req};
    assign pins_rise = pins_lvl & ~pins_old_ff;

    pin_sync #(.W(6*NA+1)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin      (pins_raw),
        .level_ff (pins_lvl)
    );

    wire [NA-1:0] st_r  = pins_rise[NA-1:0];
    wire [NA-1:0] dec_r = pins_rise[2*NA-1:NA];
    wire [NA-1:0] emg_r = pins_rise[3*NA-1:2*NA];
    wire [NA-1:0] tl_r  = pins_rise[4*NA-1:3*NA];
    wire [NA-1:0] ps_r  = pins_rise[5*NA-1:4*NA];
    wire [NA-1:0] sc_r  = pins_rise[6*NA-1:5*NA];
    wire          sys_r = pins_rise[6*NA];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [NA-1:0]     present_ff;
    reg  [3:0]        judge_ff;
    reg  [15:0]       trq_up_ff;
    reg  [15:0]       trq_lo_ff;
    reg  [15:0]       spd_up_ff;
    reg  [15:0]       spd_lo_ff;
    reg  [SW-1:0]     status_ff;
    reg  [SW-1:0]     mask_ff;
    reg  [NA-1:0]     trq_out_ff;
    reg  [NA-1:0]     spd_out_ff;

    // ----------------------------------------
    // per-axis request checks
    // ----------------------------------------
    reg [SW-1:0]  ev;
    reg [NA-1:0]  nxt_start;
    reg [NA-1:0]  nxt_stop;
    reg [NA-1:0]  nxt_tl;
    reg [NA-1:0]  nxt_ps;
    reg [NA-1:0]  nxt_sc;
    reg [NA-1:0]  trq_out;
    reg [NA-1:0]  spd_out;
    reg signed [15:0] tv;
    reg signed [15:0] sv;
    integer a;

    // status bit = type*NA + axis; type order follows the code list
    always @* begin
        ev        = {SW{1'b0}};
        nxt_start = {NA{1'b0}};
        nxt_stop  = {NA{1'b0}};
        nxt_tl    = {NA{1'b0}};
        nxt_ps    = {NA{1'b0}};
        nxt_sc    = {NA{1'b0}};
        trq_out   = {NA{1'b0}};
        spd_out   = {NA{1'b0}};
        tv        = 16'sh0000;
        sv        = 16'sh0000;
        for (a = 0; a < NA; a = a + 1) begin
            nxt_stop[a] = dec_r[a] | emg_r[a] | sys_r;
            if (tl_r[a]) begin
                if (amp_param_busy | amp_mon_busy) begin
                    ev[0*NA+a] = 1'b1;
                end else begin
                    nxt_tl[a] = 1'b1;
                end
            end
            if (st_r[a]) begin
                if (!present_ff[a]) begin
                    ev[2*NA+a] = 1'b1;
                end else if (axis_busy[a]) begin
                    ev[1*NA+a] = 1'b1;
                end else begin
                    nxt_start[a] = 1'b1;
                end
            end
            if (ps_r[a]) begin
                if (!point_active[a]) begin
                    ev[5*NA+a] = 1'b1;
                end else begin
                    nxt_ps[a] = 1'b1;
                    if (sc_r[a]) begin
                        ev[3*NA+a] = 1'b1;
                    end
                end
            end
            if (sc_r[a]) begin
                if (!point_active[a]) begin
                    ev[4*NA+a] = 1'b1;
                end else if (axis_ramping[a]) begin
                    ev[3*NA+a] = 1'b1;
                end else if (!ps_r[a]) begin
                    nxt_sc[a] = 1'b1;
                end
            end
            tv = torque_mon[a*`MON_W +: `MON_W];
            sv = speed_mon[a*`MON_W +: `MON_W];
            trq_out[a] = (tv > $signed(trq_up_ff)) || (tv < $signed(trq_lo_ff));
            spd_out[a] = (sv > $signed(spd_up_ff)) || (sv < $signed(spd_lo_ff));
            // only the entry into the out-of-band state reports
            if (judge_ff[`JB_TRQ_EN] && judge_ff[`JB_TRQ_WARN] && trq_out[a] && !trq_out_ff[a]) begin
                ev[6*NA+a] = 1'b1;
            end
            if (judge_ff[`JB_SPD_EN] && judge_ff[`JB_SPD_WARN] && spd_out[a] && !spd_out_ff[a]) begin
                ev[7*NA+a] = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // code report: lowest type, then lowest axis
    // ----------------------------------------
    reg         rep_hit;
    reg [7:0]   rep_low;
    reg [1:0]   rep_axis;
    reg [7:0]   wcode [0:`WTYPES-1];
    integer t;
    integer b;

    always @* begin
        wcode[0] = `WC_TRQ_LIMIT;
        wcode[1] = `WC_DUP_START;
        wcode[2] = `WC_NO_AXIS;
        wcode[3] = `WC_PT_SIMUL;
        wcode[4] = `WC_PT_SPEED;
        wcode[5] = `WC_PT_START;
        wcode[6] = `WC_TRQ_JUDGE;
        wcode[7] = `WC_SPD_JUDGE;
        rep_hit  = 1'b0;
        rep_low  = 8'h00;
        rep_axis = 2'h0;
        for (t = `WTYPES - 1; t >= 0; t = t - 1) begin
            for (b = NA - 1; b >= 0; b = b - 1) begin
                if (ev[t*NA+b]) begin
                    rep_hit  = 1'b1;
                    rep_low  = wcode[t];
                    rep_axis = b[1:0];
                end
            end
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // one wait state: pready is a flop, set from the first access cycle and high in the second
    wire          acc     = psel & penable & pready;
    wire          wr_acc  = acc & pwrite;
    wire [SW-1:0] clr     = (wr_acc && paddr == `OFS_STATUS) ? pwdata : {SW{1'b0}};
    wire [SW-1:0] nxt_status = (status_ff & ~clr) | ev;
    reg  [31:0]   rd_mux;
    reg           rd_err;

    always @* begin
        rd_err = 1'b0;
        case (paddr)
            `OFS_PRESENT: rd_mux = {28'h0000000, present_ff};
            `OFS_JUDGE:   rd_mux = {28'h0000000, judge_ff};
            `OFS_TRQ_UP:  rd_mux = {16'h0000, trq_up_ff};
            `OFS_TRQ_LO:  rd_mux = {16'h0000, trq_lo_ff};
            `OFS_SPD_UP:  rd_mux = {16'h0000, spd_up_ff};
            `OFS_SPD_LO:  rd_mux = {16'h0000, spd_lo_ff};
            `OFS_STATUS:  rd_mux = status_ff;
            `OFS_MASK:    rd_mux = mask_ff;
            `OFS_LAST:    rd_mux = {14'h0, warn_axis, warn_code};
            default: begin
                rd_mux = 32'h00000000;
                rd_err = 1'b1;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h00000000;
            present_ff <= `RST_PRESENT;
            judge_ff   <= `RST_JUDGE;
            trq_up_ff  <= `RST_LIM_UP;
            trq_lo_ff  <= `RST_LIM_LO;
            spd_up_ff  <= `RST_LIM_UP;
            spd_lo_ff  <= `RST_LIM_LO;
            mask_ff    <= `RST_MASK;
            status_ff  <= {SW{1'b0}};
        end else begin
            pready    <= psel & penable & ~pready;
            pslverr   <= psel & penable & ~pready & rd_err;
            prdata    <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
            status_ff <= nxt_status; // set wins over a same-cycle clear
            if (wr_acc) begin
                case (paddr)
                    `OFS_PRESENT: present_ff <= pwdata[NA-1:0];
                    `OFS_JUDGE:   judge_ff   <= pwdata[3:0];
                    `OFS_TRQ_UP:  trq_up_ff  <= pwdata[15:0];
                    `OFS_TRQ_LO:  trq_lo_ff  <= pwdata[15:0];
                    `OFS_SPD_UP:  spd_up_ff  <= pwdata[15:0];
                    `OFS_SPD_LO:  spd_lo_ff  <= pwdata[15:0];
                    `OFS_MASK:    mask_ff    <= pwdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // outputs to the axis logic and host
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_old_ff        <= {(6*NA+1){1'b0}};
            trq_out_ff         <= {NA{1'b0}};
            spd_out_ff         <= {NA{1'b0}};
            start_grant        <= {NA{1'b0}};
            stop_grant         <= {NA{1'b0}};
            torque_limit_apply <= {NA{1'b0}};
            point_start_grant  <= {NA{1'b0}};
            speed_change_grant <= {NA{1'b0}};
            warn_valid         <= 1'b0;
            warn_code          <= 16'h0000;
            warn_axis          <= 2'h0;
            irq                <= 1'b0;
        end else begin
            pins_old_ff        <= pins_lvl;
            trq_out_ff         <= trq_out;
            spd_out_ff         <= spd_out;
            start_grant        <= nxt_start;
            stop_grant         <= nxt_stop;
            torque_limit_apply <= nxt_tl;
            point_start_grant  <= nxt_ps;
            speed_change_grant <= nxt_sc;
            warn_valid         <= rep_hit;
            // code holds until the next warning
            if (rep_hit) begin
                warn_code <= `WARN_BASE | {8'h00, rep_low};
                warn_axis <= rep_axis;
            end
            irq <= |(nxt_status & mask_ff);
        end
    end
endmodule

// [hw/axis_warn_defs.vh]
`ifndef AXIS_WARN_DEFS_VH
`define AXIS_WARN_DEFS_VH

// ----------------------------------------
// sizes
// ----------------------------------------
`define AXES          4
`define MON_W         16

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_PRESENT   12'h000
`define OFS_JUDGE     12'h004
`define OFS_TRQ_UP    12'h008
`define OFS_TRQ_LO    12'h00c
`define OFS_SPD_UP    12'h010
`define OFS_SPD_LO    12'h014
`define OFS_STATUS    12'h018
`define OFS_MASK      12'h01c
`define OFS_LAST      12'h020

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PRESENT   4'hf
`define RST_JUDGE     4'h0
`define RST_LIM_UP    16'h7fff
`define RST_LIM_LO    16'h8000
`define RST_MASK      32'h00000000

// ----------------------------------------
// judgment setting bits
// ----------------------------------------
`define JB_TRQ_EN     0
`define JB_TRQ_WARN   1
`define JB_SPD_EN     2
`define JB_SPD_WARN   3

// ----------------------------------------
// warning codes and status groups
// ----------------------------------------
`define WARN_BASE     16'hb000
`define WC_TRQ_LIMIT  8'h04
`define WC_DUP_START  8'h10
`define WC_NO_AXIS    8'h20
`define WC_PT_SIMUL   8'h30
`define WC_PT_SPEED   8'h31
`define WC_PT_START   8'h32
`define WC_TRQ_JUDGE  8'h50
`define WC_SPD_JUDGE  8'h51
`define WTYPES        8

`endif

// [hw/pin_sync.v]
`timescale 1ns/1ps
// three-stage pin synchroniser; the output moves only when stages two and three agree
module pin_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] pin,
    output reg  [W-1:0] level_ff
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff    <= {W{1'b0}};
            s2_ff    <= {W{1'b0}};
            s3_ff    <= {W{1'b0}};
            level_ff <= {W{1'b0}};
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    level_ff[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule

// [bench/axis_warn_chk.sv]
`timescale 1ns/1ps
`include "axis_warn_defs.vh"
module axis_warn_chk (
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    input wire [`AXES-1:0]  start_grant,
    input wire [`AXES-1:0]  torque_limit_apply,
    input wire [`AXES-1:0]  point_start_grant,
    input wire [`AXES-1:0]  speed_change_grant,
    input wire [`AXES-1:0]  axis_busy,
    input wire [`AXES-1:0]  axis_ramping,
    input wire [`AXES-1:0]  point_active,
    input wire              amp_param_busy,
    input wire              amp_mon_busy,
    input wire              warn_valid,
    input wire [15:0]       warn_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // bus timing
    // ----------------------------------------
    sequence setup_then_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_one_wait: assert property (setup_then_access |-> !pready ##1 pready) else $error("ready not after one wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable) else $error("error outside access");
    a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("read data outside read");
    // ----------------------------------------
    // request outcomes
    // ----------------------------------------
    a_code_range: assert property (warn_valid |-> warn_code[15:8] == 8'hb0) else $error("code out of range");
    a_trq_skipped: assert property (|torque_limit_apply |-> !$past(amp_param_busy) && !$past(amp_mon_busy))
        else $error("torque limit applied while amplifier busy");
    a_busy_refused: assert property (|start_grant |-> (start_grant & $past(axis_busy)) == 0)
        else $error("start granted on busy axis");
    a_point_wins: assert property (|point_start_grant |-> (point_start_grant & speed_change_grant) == 0)
        else $error("speed change granted with point start");
    a_pt_inactive: assert property (|point_start_grant |-> (point_start_grant & ~$past(point_active)) == 0)
        else $error("point start granted while inactive");
    a_speed_refused: assert property (|speed_change_grant |->
        (speed_change_grant & ($past(axis_ramping) | ~$past(point_active))) == 0) else $error("bad speed change grant");
endmodule
bind axis_request_warning_checker axis_warn_chk chk (.*);

// [bench/host_req.sv]
`timescale 1ns/1ps
module host_req (
    input  wire       pclk,
    input  wire [6:0] cmd,
    input  wire [1:0] req_axis,
    output reg  [3:0] start_req = 4'h0,
    output reg  [3:0] decel_stop_req = 4'h0,
    output reg  [3:0] emg_stop_req = 4'h0,
    output reg  [3:0] torque_limit_req = 4'h0,
    output reg  [3:0] point_start_req = 4'h0,
    output reg  [3:0] point_speed_req = 4'h0,
    output reg        sys_stop_req = 1'b0
);
    wire [3:0] onehot = 4'h1 << req_axis;
    // ----------------------------------------
    // contacts
    // ----------------------------------------
    // requests go to the axis in req_axis whether or not the bench expects a refusal
    always @(posedge pclk) begin
        start_req        <= cmd[0] ? onehot : 4'h0;
        decel_stop_req   <= cmd[1] ? onehot : 4'h0;
        emg_stop_req     <= cmd[2] ? onehot : 4'h0;
        torque_limit_req <= cmd[3] ? onehot : 4'h0;
        point_start_req  <= cmd[4] ? onehot : 4'h0;
        point_speed_req  <= cmd[5] ? onehot : 4'h0;
        sys_stop_req     <= cmd[6];
    end
endmodule

// [bench/test_axis_request_warning_checker.sv]
`timescale 1ns/1ps
`include "axis_warn_defs.vh"
module test_axis_request_warning_checker;
    reg          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0]  paddr = 12'h000;
    reg  [31:0]  pwdata = 32'h0, lfsr = 32'hd7de, rd = 32'h0, mask_v = 32'h0;
    reg  [3:0]   axis_busy = 4'h0, axis_ramping = 4'h0, point_active = 4'h0;
    reg          amp_param_busy = 1'b0, amp_mon_busy = 1'b0, err = 1'b0, clr = 1'b0;
    reg  [63:0]  torque_mon = 64'h0, speed_mon = 64'h0;
    reg  [6:0]   cmd = 7'h00;
    reg  [1:0]   req_axis = 2'h0;
    reg  [5:0]   seen = 6'h0;
    wire [31:0]  prdata;
    wire         pready, pslverr, sys_stop_req, warn_valid, irq;
    wire [3:0]   start_req, decel_stop_req, emg_stop_req, torque_limit_req, point_start_req, point_speed_req;
    wire [3:0]   start_grant, stop_grant, torque_limit_apply, point_start_grant, speed_change_grant;
    wire [15:0]  warn_code;
    wire [1:0]   warn_axis;
    integer      n_fail = 0, n_compared = 0, k, j;
    localparam [127:0] RV = {32'h0, `RST_LIM_LO, `RST_LIM_UP, `RST_LIM_LO, `RST_LIM_UP, 12'h0, `RST_JUDGE, 12'h0,
        `RST_PRESENT};
    localparam [63:0] WCS = {`WC_SPD_JUDGE, `WC_TRQ_JUDGE, `WC_PT_START, `WC_PT_SPEED, `WC_PT_SIMUL, `WC_NO_AXIS,
        `WC_DUP_START, `WC_TRQ_LIMIT};
    axis_request_warning_checker dut (.*);
    host_req host (.*);
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        seen <= clr ? 6'h0 : seen | {warn_valid, speed_change_grant[req_axis], point_start_grant[req_axis],
            torque_limit_apply[req_axis], stop_grant[req_axis], start_grant[req_axis]};
    end
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected {grants, warning types} for one axis
    function [12:0] model(input [6:0] c, input pr, b, r, p, ab);
        reg [7:0] t;
        reg [4:0] g;
        begin
            t = 8'h0;
            g = 5'h0;
            if (c[0]) t[2] = !pr;
            if (c[0] && pr) begin
                if (b) t[1] = 1'b1;
                else g[0] = 1'b1;
            end
            if (c[1] | c[2] | c[6]) g[1] = 1'b1;
            if (c[3]) begin
                if (ab) t[0] = 1'b1;
                else g[2] = 1'b1;
            end
            if (c[4]) begin
                if (p) g[3] = 1'b1;
                else t[5] = 1'b1;
            end
            if (c[5]) begin
                if (!p) t[4] = 1'b1;
                else if (c[4] | r) t[3] = 1'b1;
                else g[4] = 1'b1;
            end
            model = {g, t};
        end
    endfunction
    // ----------------------------------------
    // bus and compare
    // ----------------------------------------
    task check(input [8*8:1] nm, input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            do begin
                @(posedge pclk);
                t = t + 1;
            end while (pready !== 1'b1 && t < 50);
            if (pready !== 1'b1) n_fail = n_fail + 1;
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task fire(input [6:0] c, input pr);
        reg [12:0] e;
        reg [31:0] st;
        reg [15:0] ec;
        integer i, lo;
        begin
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            cmd <= c;
            e = model(c, pr, axis_busy[req_axis], axis_ramping[req_axis], point_active[req_axis],
                amp_param_busy | amp_mon_busy);
            repeat (6) @(posedge pclk);
            cmd <= 7'h00;
            repeat (8) @(posedge pclk);
            st = 32'h0;
            lo = -1;
            for (i = 7; i >= 0; i = i - 1) begin
                if (e[i]) begin
                    st[i * 4 + req_axis] = 1'b1;
                    lo = i;
                end
            end
            check("grants", {26'h0, seen}, {26'h0, |e[7:0], e[12:8]});
            apb(1'b0, `OFS_STATUS, 32'h0);
            check("status", rd, st);
            check("irq", {31'h0, irq}, {31'h0, |(st & mask_v)});
            if (lo >= 0) begin
                ec = `WARN_BASE | {8'h0, WCS[8 * lo +: 8]};
                check("code", {16'h0, warn_code}, {16'h0, ec});
                check("axis", {30'h0, warn_axis}, {30'h0, req_axis});
                apb(1'b0, `OFS_LAST, 32'h0);
                check("last", rd, {14'h0, req_axis, ec});
            end
            apb(1'b1, `OFS_STATUS, st);
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        #100000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            apb(1'b0, k * 4, 32'h0);
            check("reset", rd, {16'h0, RV[16 * k +: 16]});
        end
        apb(1'b0, 12'h024, 32'h0);
        check("slverr", {rd[30:0], err}, 32'h1);
        // a running axis is busy; ramping only inside point control to keep outcomes unambiguous
        for (k = 0; k < 64; k = k + 1) begin
            lfsr = nxt(lfsr);
            mask_v = lfsr;
            apb(1'b1, `OFS_MASK, lfsr);
            lfsr = nxt(lfsr);
            req_axis <= lfsr[1:0];
            point_active <= {3'h0, lfsr[2]} << lfsr[1:0];
            axis_ramping <= {3'h0, lfsr[3] & lfsr[2]} << lfsr[1:0];
            axis_busy <= {3'h0, |lfsr[4:2]} << lfsr[1:0];
            amp_param_busy <= lfsr[5];
            amp_mon_busy <= lfsr[6] & lfsr[7];
            fire(lfsr[14:8], 1'b1);
        end
        axis_busy <= 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            req_axis <= k[1:0];
            apb(1'b1, `OFS_PRESENT, ~(32'h1 << k));
            fire(7'h01, 1'b0);
        end
        apb(1'b1, `OFS_PRESENT, 32'hf);
        for (k = 0; k < 4; k = k + 1) apb(1'b1, `OFS_TRQ_UP + k * 4, k[0] ? 32'hff9c : 32'h64);
        for (j = 0; j < 16; j = j + 1) begin
            apb(1'b1, `OFS_JUDGE, j);
            // both sides of each band get crossed over the loop
            torque_mon <= (j[2] ? 64'hff38 : 64'h00c8) << (16 * j[1:0]);
            speed_mon <= (j[0] ? 64'h0100 : 64'hff00) << (16 * j[1:0]);
            repeat (10) @(posedge pclk);
            apb(1'b0, `OFS_STATUS, 32'h0);
            check("judge", rd, ({31'h0, j[1:0] == 2'b11} << (24 + j[1:0])) |
                ({31'h0, j[3:2] == 2'b11} << (28 + j[1:0])));
            torque_mon <= 64'h0;
            speed_mon <= 64'h0;
            repeat (10) @(posedge pclk);
            apb(1'b1, `OFS_STATUS, 32'hffffffff);
        end
        end_of_test;
    end
endmodule
